// >>> shared/hwrc_map.vh
`ifndef HWRC_MAP_VH
`define HWRC_MAP_VH

// register byte offsets
`define HWRC_OFF_STATUS   5'h00
`define HWRC_OFF_WSEL     5'h04
`define HWRC_OFF_ICTL     5'h08
`define HWRC_OFF_T0CTL    5'h0c
`define HWRC_OFF_T1CTL    5'h10
`define HWRC_OFF_PORT     5'h14
`define HWRC_ADDR_W       5

// reset values
`define HWRC_RST_WSEL     8'h07
`define HWRC_RST_ICTL     8'h00
`define HWRC_RST_TMRC     8'h08
`define HWRC_RST_PORT     8'hff

// writable bits
`define HWRC_WMASK_ICTL   8'h7f
`define HWRC_WMASK_TMRC   8'hdf

// status bit positions
`define HWRC_ST_PDN       4
`define HWRC_ST_TMO       5
`define HWRC_ST_HALT      6

// interrupt control bit positions
`define HWRC_IC_EMI       0
`define HWRC_IC_EN_LO     1
`define HWRC_IC_FLAG_LO   4
`define HWRC_NUM_IRQ      3

// start-up delay
`define HWRC_WAKE_CYCLES  1024
`define HWRC_WAKE_W       11

`endif

// >>> hdl/hwrc_startup_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "hwrc_map.vh"

module hwrc_startup_timer #(
  parameter CYCLES = `HWRC_WAKE_CYCLES,
  parameter W      = `HWRC_WAKE_W
) (
  input  wire ref_clk_in,
  input  wire rstn_in,
  input  wire start_in,
  output reg  done_out
);

  localparam [W-1:0] LAST = CYCLES - 1;

  reg [W-1:0] cnt;
  reg         run;

  // counts CYCLES clocks from start, then pulses done
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt      <= {W{1'b0}};
      run      <= 1'b0;
      done_out <= 1'b0;
    end else if (start_in) begin
      cnt      <= LAST;
      run      <= 1'b1;
      done_out <= 1'b0;
    end else if (run && cnt == {W{1'b0}}) begin
      run      <= 1'b0;
      done_out <= 1'b1;
    end else begin
      if (run) begin
        cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
      end
      done_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> hdl/hwrc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "hwrc_map.vh"

module hwrc_top #(
  parameter [7:0] PORT_WAKE_MASK = 8'hff,
  parameter       WDT_OSC_SEL    = 1'b1,
  parameter       WAKE_CYCLES    = `HWRC_WAKE_CYCLES
) (
  input  wire        ref_clk_in,
  input  wire        rstn_in,
  input  wire        ext_clear_pin_n_in,
  input  wire        halt_instr_in,
  input  wire        watchdog_clear_instr_in,
  input  wire        wdt_overflow_in,
  input  wire        stack_full_in,
  input  wire        time_base_evt_in,
  input  wire [1:0]  timer_ovf_in,
  input  wire [7:0]  first_io_port_in,
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output wire [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  output wire        sys_osc_en_out,
  output wire        wdt_osc_en_out,
  output wire        halted_out,
  output wire        io_hold_out,
  output wire        core_run_out,
  output wire        wdt_clear_out,
  output wire        chip_reset_out,
  output wire        pc_sp_reset_out,
  output wire        resume_next_out,
  output wire        irq_ack_out,
  output wire        power_down_flag_out,
  output wire        timeout_flag_out,
  output wire [7:0]  watchdog_select_reg_out,
  output wire [7:0]  interrupt_control_reg_out,
  output wire [7:0]  timer0_control_reg_out,
  output wire [7:0]  timer1_control_reg_out,
  output wire [7:0]  first_io_port_latch_out
);

  localparam [2:0] ST_PUP  = 3'h0;
  localparam [2:0] ST_RUN  = 3'h1;
  localparam [2:0] ST_HALT = 3'h2;
  localparam [2:0] ST_WAKE = 3'h3;
  localparam [2:0] ST_ACK  = 3'h4;
  localparam [2:0] ST_PIN  = 3'h5;

  localparam NI = `HWRC_NUM_IRQ;

  function [7:0] merge_wr;
    input [7:0] cur;
    input [7:0] wdat;
    input [7:0] wmask;
    begin
      merge_wr = (cur & ~wmask) | (wdat & wmask);
    end
  endfunction

  // pin synchronisers
  reg [1:0] pin_sync;
  reg [7:0] port_meta;
  reg [7:0] port_sync;
  reg [7:0] port_prev;

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_sync  <= 2'h3;
      port_meta <= `HWRC_RST_PORT;
      port_sync <= `HWRC_RST_PORT;
      port_prev <= `HWRC_RST_PORT;
    end else begin
      pin_sync  <= {pin_sync[0], ext_clear_pin_n_in};
      port_meta <= first_io_port_in;
      port_sync <= port_meta;
      port_prev <= port_sync;
    end
  end

  wire pin_low = ~pin_sync[1];

  reg [2:0]    state;
  reg [2:0]    next_state;
  reg          wake_irq_kind;
  reg [NI-1:0] wake_allow;
  reg          power_down_flag;
  reg          timeout_flag;
  reg [7:0]    watchdog_select_reg;
  reg [7:0]    interrupt_control_reg;
  reg [7:0]    timer0_control_reg;
  reg [7:0]    timer1_control_reg;
  reg [7:0]    first_io_port_latch;
  reg          sys_osc_en;
  reg          wdt_osc_en;
  reg          halted;
  reg          core_run;
  reg          wdt_clear;
  reg          chip_reset;
  reg          pc_sp_reset;
  reg          resume_next;
  reg          irq_ack;
  reg          delay_start;
  wire         delay_done;

  // bus slave state
  reg          waitreq;
  reg  [31:0]  rdata;
  wire         bus_req = (avs_read_in | avs_write_in) & waitreq;
  wire         bus_wr  = bus_req & avs_write_in & avs_byteenable_in[0];
  wire [7:0]   wdat    = avs_writedata_in[7:0];

  // interrupt flag set events
  wire [NI-1:0] irq_set = {timer_ovf_in[1], timer_ovf_in[0], time_base_evt_in};
  wire [NI-1:0] irq_flags = interrupt_control_reg[`HWRC_IC_FLAG_LO +: NI];
  wire [NI-1:0] irq_en = interrupt_control_reg[`HWRC_IC_EN_LO +: NI];
  wire          emi = interrupt_control_reg[`HWRC_IC_EMI];

  wire port_fall = |(port_prev & ~port_sync & PORT_WAKE_MASK);
  wire [NI-1:0] irq_wake = irq_set & wake_allow;
  wire any_irq_wake = |irq_wake;
  wire irq_service = emi & |(irq_wake & irq_en) & ~stack_full_in;
  wire wake_any = port_fall | any_irq_wake | wdt_overflow_in;

  // full reset when pin held low or watchdog overflow while running
  wire full_reset = pin_low | (state == ST_RUN & wdt_overflow_in);

  always @* begin
    next_state = state;
    case (state)
      ST_PUP: begin
        if (pin_low) begin
          next_state = ST_PIN;
        end else if (delay_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pin_low) begin
          next_state = ST_PIN;
        end else if (halt_instr_in && !wdt_overflow_in) begin
          next_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (pin_low) begin
          next_state = ST_PIN;
        end else if (wake_any) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (pin_low) begin
          next_state = ST_PIN;
        end else if (delay_done) begin
          next_state = wake_irq_kind ? ST_ACK : ST_RUN;
        end
      end
      ST_ACK: begin
        next_state = pin_low ? ST_PIN : ST_RUN;
      end
      ST_PIN: begin
        if (!pin_low) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_PUP;
      end
    endcase
  end

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state         <= ST_PUP;
      wake_irq_kind <= 1'b0;
      wake_allow    <= {NI{1'b0}};
      sys_osc_en    <= 1'b1;
      wdt_osc_en    <= 1'b1;
      halted        <= 1'b0;
      core_run      <= 1'b0;
      wdt_clear     <= 1'b1;
      chip_reset    <= 1'b1;
      pc_sp_reset   <= 1'b0;
      resume_next   <= 1'b0;
      irq_ack       <= 1'b0;
      delay_start   <= 1'b1;
    end else begin
      state       <= next_state;
      sys_osc_en  <= (next_state != ST_HALT);
      wdt_osc_en  <= WDT_OSC_SEL ? 1'b1 : (next_state != ST_HALT);
      halted      <= (next_state == ST_HALT);
      core_run    <= (next_state == ST_RUN);
      chip_reset  <= full_reset;
      wdt_clear   <= full_reset | (state == ST_RUN & (halt_instr_in | watchdog_clear_instr_in));
      // warm reset of pc and sp
      pc_sp_reset <= (state == ST_HALT) & ~pin_low & wdt_overflow_in;
      delay_start <= (state == ST_HALT) & ~pin_low & wake_any;
      resume_next <= (state == ST_WAKE) & ~pin_low & delay_done & ~wake_irq_kind;
      irq_ack     <= (state == ST_ACK) & ~pin_low;
      if (state == ST_RUN && next_state == ST_HALT) begin
        wake_allow <= ~irq_flags;
      end
      if (state == ST_HALT && wake_any) begin
        wake_irq_kind <= ~wdt_overflow_in & ~port_fall & irq_service;
      end
    end
  end

  // flags and reset-valued registers
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      power_down_flag       <= 1'b0;
      timeout_flag          <= 1'b0;
      watchdog_select_reg   <= `HWRC_RST_WSEL;
      interrupt_control_reg <= `HWRC_RST_ICTL;
      timer0_control_reg    <= `HWRC_RST_TMRC;
      timer1_control_reg    <= `HWRC_RST_TMRC;
      first_io_port_latch   <= `HWRC_RST_PORT;
    end else begin
      if (pin_low) begin
        // pin wake from halt gives 0,1
        if (state == ST_HALT) begin
          timeout_flag    <= 1'b0;
          power_down_flag <= 1'b1;
        end
      end else if (state == ST_HALT && wdt_overflow_in) begin
        timeout_flag    <= 1'b1;
        power_down_flag <= 1'b1;
      end else if (state == ST_RUN) begin
        if (wdt_overflow_in) begin
          timeout_flag <= 1'b1;
        end else if (halt_instr_in) begin
          power_down_flag <= 1'b1;
          timeout_flag    <= 1'b0;
        end else if (watchdog_clear_instr_in) begin
          power_down_flag <= 1'b0;
          timeout_flag    <= 1'b0;
        end
      end
      if (full_reset) begin
        watchdog_select_reg   <= `HWRC_RST_WSEL;
        interrupt_control_reg <= `HWRC_RST_ICTL;
        timer0_control_reg    <= `HWRC_RST_TMRC;
        timer1_control_reg    <= `HWRC_RST_TMRC;
        first_io_port_latch   <= `HWRC_RST_PORT;
      end else begin
        // only bus writes and flag events change these
        interrupt_control_reg[`HWRC_IC_FLAG_LO +: NI] <=
          (bus_wr && avs_address_in == `HWRC_OFF_ICTL ? wdat[`HWRC_IC_FLAG_LO +: NI] : irq_flags)
          | irq_set;
        if (bus_wr) begin
          case (avs_address_in)
            `HWRC_OFF_WSEL: begin
              watchdog_select_reg <= wdat;
            end
            `HWRC_OFF_ICTL: begin
              interrupt_control_reg[`HWRC_IC_FLAG_LO-1:0] <= wdat[`HWRC_IC_FLAG_LO-1:0];
            end
            `HWRC_OFF_T0CTL: begin
              timer0_control_reg <= merge_wr(timer0_control_reg, wdat, `HWRC_WMASK_TMRC);
            end
            `HWRC_OFF_T1CTL: begin
              timer1_control_reg <= merge_wr(timer1_control_reg, wdat, `HWRC_WMASK_TMRC);
            end
            `HWRC_OFF_PORT: begin
              first_io_port_latch <= wdat;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // avalon slave: one wait cycle, then answer
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      waitreq <= 1'b1;
      rdata   <= 32'h00000000;
    end else if (bus_req) begin
      waitreq <= 1'b0;
      rdata   <= 32'h00000000;
      if (avs_read_in) begin
        case (avs_address_in)
          `HWRC_OFF_STATUS: begin
            rdata[`HWRC_ST_PDN]  <= power_down_flag;
            rdata[`HWRC_ST_TMO]  <= timeout_flag;
            rdata[`HWRC_ST_HALT] <= halted;
          end
          `HWRC_OFF_WSEL: begin
            rdata[7:0] <= watchdog_select_reg;
          end
          `HWRC_OFF_ICTL: begin
            rdata[7:0] <= interrupt_control_reg & `HWRC_WMASK_ICTL;
          end
          `HWRC_OFF_T0CTL: begin
            rdata[7:0] <= timer0_control_reg;
          end
          `HWRC_OFF_T1CTL: begin
            rdata[7:0] <= timer1_control_reg;
          end
          `HWRC_OFF_PORT: begin
            rdata[7:0] <= first_io_port_latch;
          end
          default: begin
            rdata <= 32'h00000000;
          end
        endcase
      end
    end else begin
      waitreq <= 1'b1;
    end
  end

  // wait counter on the system clock
  hwrc_startup_timer #(
    .CYCLES (WAKE_CYCLES),
    .W      (`HWRC_WAKE_W)
  ) hwrc_startup_timer_i (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .start_in   (delay_start),
    .done_out   (delay_done)
  );

  assign avs_readdata_out          = rdata;
  assign avs_waitrequest_out       = waitreq;
  assign sys_osc_en_out            = sys_osc_en;
  assign wdt_osc_en_out            = wdt_osc_en;
  assign halted_out                = halted;
  assign io_hold_out               = halted;
  assign core_run_out              = core_run;
  assign wdt_clear_out             = wdt_clear;
  assign chip_reset_out            = chip_reset;
  assign pc_sp_reset_out           = pc_sp_reset;
  assign resume_next_out           = resume_next;
  assign irq_ack_out               = irq_ack;
  assign power_down_flag_out       = power_down_flag;
  assign timeout_flag_out          = timeout_flag;
  assign watchdog_select_reg_out   = watchdog_select_reg;
  assign interrupt_control_reg_out = interrupt_control_reg;
  assign timer0_control_reg_out    = timer0_control_reg;
  assign timer1_control_reg_out    = timer1_control_reg;
  assign first_io_port_latch_out   = first_io_port_latch;

endmodule

`default_nettype wire

// >>> sim/hwrc_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module hwrc_core_model (
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       core_run_in,
  input  wire logic [2:0] cmd_in,
  output logic            halt_out,
  output logic            clear_out,
  output logic            wdt_ovf_out
);
  // cmd_in: halt, watchdog clear, watchdog overflow requests
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      halt_out    <= 1'b0;
      clear_out   <= 1'b0;
      wdt_ovf_out <= 1'b0;
    end else begin
      halt_out    <= cmd_in[0] & core_run_in;
      clear_out   <= cmd_in[1] & core_run_in;
      wdt_ovf_out <= cmd_in[2];
    end
  end
endmodule

`default_nettype wire

// >>> sim/hwrc_chk.sv
`timescale 1ns/1ps
`default_nettype none

module hwrc_chk #(
  parameter WAKE_CYCLES = 1024
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       ext_clear_pin_n_in,
  input  wire logic       halt_instr_in,
  input  wire logic       watchdog_clear_instr_in,
  input  wire logic       wdt_overflow_in,
  input  wire logic       sys_osc_en_out,
  input  wire logic       wdt_osc_en_out,
  input  wire logic       halted_out,
  input  wire logic       io_hold_out,
  input  wire logic       core_run_out,
  input  wire logic       wdt_clear_out,
  input  wire logic       chip_reset_out,
  input  wire logic       pc_sp_reset_out,
  input  wire logic       resume_next_out,
  input  wire logic       irq_ack_out,
  input  wire logic       power_down_flag_out,
  input  wire logic       timeout_flag_out,
  input  wire logic [7:0] watchdog_select_reg_out,
  input  wire logic [7:0] first_io_port_latch_out
);
  logic [15:0] wcnt;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  // cycles since the halt state was left
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      wcnt <= 16'h0000;
    else if (halted_out)
      wcnt <= 16'h0000;
    else if (wcnt != 16'hffff)
      wcnt <= wcnt + 16'h0001;
  end

  halt_enter_a: assert property (halt_instr_in && core_run_out && !wdt_overflow_in &&
    ext_clear_pin_n_in |=> halted_out && !sys_osc_en_out && wdt_osc_en_out && wdt_clear_out &&
    power_down_flag_out && !timeout_flag_out) else $error("halt entry wrong");
  halt_osc_a: assert property (halted_out |-> !sys_osc_en_out && io_hold_out)
    else $error("oscillator or port hold wrong in halt");
  halt_hold_a: assert property (disable iff (!rstn_in || !ext_clear_pin_n_in)
    halted_out && $past(halted_out) |-> $stable(first_io_port_latch_out) &&
    $stable(watchdog_select_reg_out)) else $error("state changed in halt");
  clear_cmd_a: assert property (watchdog_clear_instr_in && core_run_out && !halt_instr_in &&
    !wdt_overflow_in && ext_clear_pin_n_in |=> wdt_clear_out && !power_down_flag_out &&
    !timeout_flag_out) else $error("watchdog clear wrong");
  warm_wake_a: assert property (halted_out && wdt_overflow_in && ext_clear_pin_n_in
    |=> pc_sp_reset_out && !chip_reset_out && timeout_flag_out && power_down_flag_out &&
    $stable(watchdog_select_reg_out)) else $error("warm wake wrong");
  run_wdt_a: assert property (core_run_out && wdt_overflow_in && ext_clear_pin_n_in
    |=> chip_reset_out && timeout_flag_out && $stable(power_down_flag_out) ##2
    watchdog_select_reg_out == 8'h07) else $error("watchdog reset in run wrong");
  pin_reset_a: assert property (!ext_clear_pin_n_in [*4] |=> chip_reset_out && !core_run_out &&
    wdt_clear_out && first_io_port_latch_out == 8'hff) else $error("pin reset wrong");
  pin_bypass_a: assert property ($rose(ext_clear_pin_n_in) |-> ##[1:6] core_run_out)
    else $error("pin reset release slow");
  wake_delay_a: assert property (resume_next_out |-> wcnt >= WAKE_CYCLES &&
    wcnt <= WAKE_CYCLES + 4) else $error("wake delay wrong");
  irq_delay_a: assert property (irq_ack_out |-> wcnt >= WAKE_CYCLES + 1 &&
    wcnt <= WAKE_CYCLES + 5) else $error("interrupt entry delay wrong");

  cover property (resume_next_out);
  cover property (irq_ack_out);
  cover property (pc_sp_reset_out);
endmodule

bind hwrc_top hwrc_chk #(.WAKE_CYCLES(WAKE_CYCLES)) hwrc_chk_i (.*);

`default_nettype wire

// >>> sim/hwrc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module hwrc_tb_top;
  localparam DLY = 8;
  logic        ref_clk_in;
  logic        rstn_in;
  logic        pin_n;
  logic        stack_full;
  logic [2:0]  cmd;
  logic [1:0]  tovf;
  logic [7:0]  port;
  logic [4:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [7:0]  q;
  wire logic   halt_i;
  wire logic   clr_i;
  wire logic   wdt_i;
  wire logic   wreq;
  wire logic   run;
  wire logic   halted;
  wire logic   rnext;
  wire logic   ack;
  wire logic [31:0] rdata;
  wire logic [7:0]  ictl;
  wire logic [7:0]  t0c;
  wire logic [7:0]  t1c;
  int          bad_count;
  int          n_compared;
  int          wn;

  hwrc_top #(.WAKE_CYCLES(DLY)) hwrc_top_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .ext_clear_pin_n_in(pin_n), .halt_instr_in(halt_i), .watchdog_clear_instr_in(clr_i),
    .wdt_overflow_in(wdt_i), .stack_full_in(stack_full), .time_base_evt_in(1'b0),
    .timer_ovf_in(tovf), .first_io_port_in(port), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .sys_osc_en_out(),
    .wdt_osc_en_out(), .halted_out(halted), .io_hold_out(), .core_run_out(run),
    .wdt_clear_out(), .chip_reset_out(), .pc_sp_reset_out(), .resume_next_out(rnext),
    .irq_ack_out(ack), .power_down_flag_out(), .timeout_flag_out(),
    .watchdog_select_reg_out(), .interrupt_control_reg_out(ictl), .timer0_control_reg_out(t0c),
    .timer1_control_reg_out(t1c), .first_io_port_latch_out());

  hwrc_core_model hwrc_core_model_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .core_run_in(run), .cmd_in(cmd), .halt_out(halt_i), .clear_out(clr_i), .wdt_ovf_out(wdt_i));

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= {24'h0, d};
    // waitrequest and read data are taken at the same rising edge
    @(posedge ref_clk_in);
    while (wreq !== 1'b0 && n < 20) begin
      @(posedge ref_clk_in);
      n++;
    end
    chk("bus answer", 8'h1, {7'h0, n < 20});
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task rchk(input logic [4:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk("register", exp, q);
  endtask

  // k: 0 run, 1 halted, 2 resume, 3 interrupt entry
  task wait_ev(input int k, input int lim);
    wn = 0;
    @(negedge ref_clk_in);
    while ((k == 0 ? run : k == 1 ? halted : k == 2 ? rnext : ack) !== 1'b1 && wn < lim) begin
      @(negedge ref_clk_in);
      wn++;
    end
    chk("event seen", 8'h1, {7'h0, wn < lim});
  endtask

  task pulse(input int b);
    @(posedge ref_clk_in);
    cmd <= 3'b001 << b;
    @(posedge ref_clk_in);
    cmd <= 3'b000;
  endtask

  task halt_now;
    pulse(0);
    wait_ev(1, 8);
  endtask

  task t_power_up;
    wait_ev(0, DLY + 10);
    chk("startup wait", 8'h1, {7'h0, wn >= DLY});
    chk("timer0 control out", 8'h08, t0c);
    chk("timer1 control out", 8'h08, t1c);
    rchk(5'h04, 8'h07);
    rchk(5'h08, 8'h00);
    rchk(5'h0c, 8'h08);
    rchk(5'h10, 8'h08);
    rchk(5'h14, 8'hff);
    rchk(5'h00, 8'h00);
    rchk(5'h18, 8'h00);
  endtask

  task t_port_wake;
    bus(1'b1, 5'h14, 8'h5a);
    halt_now();
    rchk(5'h00, 8'h50);
    @(posedge ref_clk_in);
    port <= 8'hfe;
    wait_ev(2, DLY + 12);
    chk("wake delay", 8'h1, {7'h0, wn >= DLY});
    rchk(5'h14, 8'h5a);
    port <= 8'hff;
  endtask

  task t_irq_wake(input logic full);
    bus(1'b1, 5'h08, 8'h05);
    stack_full <= full;
    halt_now();
    @(posedge ref_clk_in);
    tovf <= 2'b01;
    @(posedge ref_clk_in);
    tovf <= 2'b00;
    wait_ev(full ? 2 : 3, DLY + 12);
    chk("entry delay", 8'h1, {7'h0, wn >= DLY + !full});
    bus(1'b1, 5'h08, 8'h00);
    stack_full <= 1'b0;
  endtask

  task t_preset;
    bus(1'b1, 5'h08, 8'h24);
    halt_now();
    @(posedge ref_clk_in);
    tovf <= 2'b01;
    @(posedge ref_clk_in);
    tovf <= 2'b00;
    repeat (DLY + 12) @(posedge ref_clk_in);
    chk("still halted", 8'h1, {7'h0, halted});
    pulse(2);
    wait_ev(0, DLY + 12);
    rchk(5'h00, 8'h30);
    rchk(5'h08, 8'h24);
    chk("interrupt control out", 8'h24, ictl);
    bus(1'b1, 5'h08, 8'h00);
  endtask

  task t_run_wdt;
    pulse(1);
    rchk(5'h00, 8'h00);
    bus(1'b1, 5'h04, 8'h03);
    pulse(2);
    repeat (4) @(posedge ref_clk_in);
    wait_ev(0, 20);
    rchk(5'h00, 8'h20);
    rchk(5'h04, 8'h07);
  endtask

  task t_pin(input logic in_halt, input logic [7:0] st);
    // a run-time watchdog reset first sets the time-out flag to be kept
    if (!in_halt)
      pulse(2);
    bus(1'b1, 5'h14, 8'h33);
    if (in_halt)
      halt_now();
    @(posedge ref_clk_in);
    pin_n <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    pin_n <= 1'b1;
    wait_ev(0, 8);
    rchk(5'h00, st);
    rchk(5'h14, 8'hff);
  endtask

  task wrap_up;
    $display("compared %0d errors %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    $display("Error watchdog expected finish seen timeout");
    bad_count++;
    wrap_up();
  end

  initial begin
    rstn_in = 1'b0;
    pin_n = 1'b1;
    stack_full = 1'b0;
    cmd = 3'b000;
    tovf = 2'b00;
    port = 8'hff;
    addr = 5'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    bad_count = 0;
    n_compared = 0;
    repeat (16) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    t_power_up();
    t_port_wake();
    t_irq_wake(1'b0);
    t_irq_wake(1'b1);
    t_preset();
    t_run_wdt();
    t_pin(1'b1, 8'h10);
    t_pin(1'b0, 8'h30);
    wrap_up();
  end
endmodule

`default_nettype wire
